//--- verif/tpo_pin_model.sv
`timescale 1ns/100ps

// ****************************************
// trigger and clear-level pin driver
// ****************************************
module tpo_pin_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic clear_level,
    output logic trigger_input,
    output logic external_trigger_input
);
    logic [2:0] hold;

    // trigger held high long enough to pass the input synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            hold <= 3'h0;
        end else if (fire) begin
            hold <= 3'h6;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end

    assign trigger_input = (hold != 3'h0);
    assign external_trigger_input = clear_level;
endmodule : tpo_pin_model

//--- verif/tpo_timer_pwm_bench.sv
`timescale 1ns/100ps

module tpo_timer_pwm_bench import tpo_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fire;
    logic clear_level;
    logic trigger_input;
    logic external_trigger_input;
    logic reference_output;
    logic compare_pin_output;
    tpo_ahb_req_type bus;
    tpo_ahb_req_type req;
    tpo_ahb_rsp_type rsp;
    logic rdy_q;
    logic [31:0] rdata_q;
    logic [31:0] q;
    int failures = 0;
    int tests_run = 0;
    int nr;
    int np;
    // ctrl, mode, compare, period and high cycles per period
    logic [31:0] t_ctrl [9] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h3, 32'h3, 32'h9, 32'h11, 32'h19};
    logic [31:0] t_mode [9] = '{32'h6, 32'h6, 32'h6, 32'h47, 32'h6, 32'h6, 32'h6, 32'h6, 32'h6};
    int t_cmp [9] = '{3, 0, 9, 3, 3, 0, 3, 3, 3};
    int t_per [9] = '{9, 9, 9, 9, 9, 9, 16, 16, 16};
    int t_hi [9] = '{3, 0, 9, 6, 4, 1, 6, 6, 6};

    always #5 clk = ~clk;

    always_comb begin
        req = bus;
        req.hready = rsp.hreadyout;
    end

    // bus answer captured mid-cycle, stable across the rising edge
    always @(negedge clk) begin
        rdy_q <= rsp.hreadyout;
        rdata_q <= rsp.hrdata;
    end

    tpo_timer_pwm dut (
        .clk(clk),
        .rst(rst),
        .ahb_req(req),
        .ahb_rsp(rsp),
        .trigger_input(trigger_input),
        .external_trigger_input(external_trigger_input),
        .reference_output(reference_output),
        .compare_pin_output(compare_pin_output)
    );

    tpo_pin_model pins (
        .clk(clk),
        .rst(rst),
        .fire(fire),
        .clear_level(clear_level),
        .trigger_input(trigger_input),
        .external_trigger_input(external_trigger_input)
    );

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] expected);
        tests_run++;
        if (seen !== expected) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    task bus_access(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rdq);
        bus.haddr <= {24'h0, a};
        bus.htrans <= 2'h2;
        bus.hwrite <= wr;
        bus.hsize <= 3'h2;
        @(posedge clk);
        while (rdy_q !== 1'b1) @(posedge clk);
        bus.htrans <= 2'h0;
        bus.hwdata <= d;
        @(posedge clk);
        while (rdy_q !== 1'b1) @(posedge clk);
        rdq = rdata_q;
    endtask : bus_access

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus_access(1'b1, a, d, unused);
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] rdq);
        bus_access(1'b0, a, 32'h0, rdq);
    endtask : rd

    task count_high(input int n, output int nref, output int npin);
        nref = 0;
        npin = 0;
        repeat (n) begin
            @(negedge clk);
            nref += (reference_output === 1'b1);
            npin += (compare_pin_output === 1'b1);
        end
        @(posedge clk);
    endtask : count_high

    // stop, pass through frozen, reload 8, software update, then write ctrl (starts only if its run bit is set)
    task setup(input logic [31:0] ctrl, input logic [31:0] mode, input logic [31:0] cmp);
        // leave center mode first, then clear direction in a separate write
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CHMODE, 32'h0);
        wr(OFF_ARR, 32'h8);
        wr(OFF_CMP, cmp);
        wr(OFF_EVGEN, 32'h1);
        wr(OFF_CHMODE, mode);
        wr(OFF_CTRL, ctrl);
    endtask : setup

    task pulse_trigger;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask : pulse_trigger

    task test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // ****************************************
    // watchdog
    // ****************************************
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done;
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        bus = '0;
        bus.hsel = 1'b1;
        fire = 1'b0;
        clear_level = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({31'h0, reference_output}, 32'h0);
        rd(OFF_ARR, q);
        check(q, 32'h0000ffff);
        rd(OFF_CTRL, q);
        check(q, 32'h0);
        rd(8'h20, q);
        check(q, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            setup(t_ctrl[i], t_mode[i], 32'(t_cmp[i]));
            count_high(20, nr, np);
            count_high(10 * t_per[i], nr, np);
            check(32'(nr), 32'(10 * t_hi[i]));
            check(32'(np), t_mode[i][6] ? 32'(10 * (t_per[i] - t_hi[i])) : 32'(10 * t_hi[i]));
        end
        $display("test duty table done");
        // counter left at 0, below the compare value, while waiting
        wr(OFF_SLAVE, 32'h6);
        setup(32'h4, 32'h7, 32'h3);
        pulse_trigger;
        count_high(40, nr, np);
        check(32'(nr), 32'h6);
        rd(OFF_CTRL, q);
        check(q & 32'h1, 32'h0);
        rd(OFF_CNT, q);
        check(q, 32'h0);
        rd(OFF_STATUS, q);
        check(q, 32'h7);
        wr(OFF_STATUS, 32'h7);
        rd(OFF_STATUS, q);
        check(q, 32'h0);
        setup(32'h4, 32'h17, 32'h3);
        pulse_trigger;
        count_high(40, nr, np);
        check(32'(nr), 32'ha);
        $display("test single pulse done");
        wr(OFF_SLAVE, 32'h0);
        setup(32'h1, 32'h26, 32'h9);
        clear_level <= 1'b1;
        count_high(10, nr, np);
        count_high(20, nr, np);
        check(32'(nr), 32'h0);
        wr(OFF_CHMODE, 32'h25);
        count_high(10, nr, np);
        count_high(10, nr, np);
        check(32'(nr), 32'ha);
        wr(OFF_CHMODE, 32'h0);
        clear_level <= 1'b0;
        wr(OFF_CHMODE, 32'h26);
        count_high(20, nr, np);
        count_high(18, nr, np);
        check(32'(nr), 32'h12);
        $display("test reference clear done");
        test_done;
    end
endmodule : tpo_timer_pwm_bench

//--- verilog/tpo_pkg.sv
package tpo_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SLAVE = 8'h04;
    localparam logic [7:0] OFF_CHMODE = 8'h08;
    localparam logic [7:0] OFF_EVGEN = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_CNT = 8'h14;
    localparam logic [7:0] OFF_CMP = 8'h18;
    localparam logic [7:0] OFF_ARR = 8'h1c;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_RUN = 0;
    localparam int BIT_DIR = 1;
    localparam int BIT_SPE = 2;
    localparam int ALIGN_LO = 3;
    localparam int BIT_RLDPRE = 5;
    localparam int SMODE_LO = 0;
    localparam int BIT_ETPOL = 4;
    localparam int OMODE_LO = 0;
    localparam int BIT_CPRE = 3;
    localparam int BIT_FAST = 4;
    localparam int BIT_CLREN = 5;
    localparam int BIT_POL = 6;
    localparam int BIT_SWUPD = 0;
    localparam int BIT_CCF = 0;
    localparam int BIT_UPDF = 1;
    localparam int BIT_TRGF = 2;
    localparam int CNT_W = 16;

    // ****************************************
    // encodings and reset values
    // ****************************************
    localparam logic [2:0] OM_FROZEN = 3'h0;
    localparam logic [2:0] OM_ACTIVE = 3'h1;
    localparam logic [2:0] OM_INACTIVE = 3'h2;
    localparam logic [2:0] OM_TOGGLE = 3'h3;
    localparam logic [2:0] OM_FORCE_LO = 3'h4;
    localparam logic [2:0] OM_FORCE_HI = 3'h5;
    localparam logic [2:0] OM_PWM1 = 3'h6;
    localparam logic [2:0] OM_PWM2 = 3'h7;
    localparam logic [2:0] SMODE_TRIGGER = 3'h6;
    localparam logic [1:0] ALIGN_EDGE = 2'h0;
    localparam logic [1:0] ALIGN_DOWN = 2'h1;
    localparam logic [1:0] ALIGN_UP = 2'h2;
    localparam logic [15:0] ARR_RST = 16'hffff;

    typedef logic [CNT_W-1:0] tpo_cnt_type;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } tpo_ahb_req_type;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } tpo_ahb_rsp_type;

endpackage : tpo_pkg

//--- verilog/tpo_timer_pwm.sv
`timescale 1ns/100ps

module tpo_timer_pwm import tpo_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire tpo_ahb_req_type ahb_req,
    output tpo_ahb_rsp_type ahb_rsp,
    input wire logic trigger_input,
    input wire logic external_trigger_input,
    output logic reference_output,
    output logic compare_pin_output
);

    typedef struct packed {
        logic a_sel;
        logic a_wr;
        logic [7:0] a_off;
        logic [31:0] rdata;
        logic [2:0] trg_sync;
        logic trg_lvl;
        logic [2:0] xtrg_sync;
        logic xtrg_lvl;
        logic counter_enable_bit;
        logic dir;
        logic single_pulse_enable;
        logic [1:0] alignment_select;
        logic reload_preload_enable;
        logic [2:0] slave_mode_select;
        logic external_trigger_polarity;
        logic [2:0] output_mode_field;
        logic compare_preload_enable;
        logic fast_output_enable;
        logic reference_clear_enable;
        logic channel_polarity;
        tpo_cnt_type counter_value;
        tpo_cnt_type compare_value;
        tpo_cnt_type cmp_act;
        tpo_cnt_type auto_reload_value;
        tpo_cnt_type arr_act;
        logic cmp_flag;
        logic upd_flag;
        logic trg_flag;
        logic ref_lvl;
        logic prev_res;
        logic [2:0] prev_mode;
        logic clr_hold;
        logic fast_hold;
        logic ref_out;
        logic pin_out;
    } tpo_state_type;

    tpo_state_type q;
    tpo_state_type n;
    logic acc, wr, center, pwm, res, match, trig_edge, trig_start;
    logic cnt_wr, ctrl_wr, sw_upd, tick, cnt_uev, update_event, fast_lvl, xtrg_f, flag_ok;
    logic [31:0] wd;
    logic [2:0] mode;

    assign ahb_rsp = '{hreadyout: 1'b1, hresp: 1'b0, hrdata: q.rdata};
    assign reference_output = q.ref_out;
    assign compare_pin_output = q.pin_out;

    always_comb begin
        n = q;
        mode = q.output_mode_field;
        acc = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
        wr = q.a_sel & q.a_wr;
        wd = ahb_req.hwdata;
        center = q.alignment_select != ALIGN_EDGE;
        pwm = (mode == OM_PWM1) | (mode == OM_PWM2);
        res = q.dir ? (q.counter_value <= q.cmp_act) : (q.counter_value < q.cmp_act);
        match = q.counter_value == q.cmp_act;
        trig_edge = (q.trg_sync[1] == q.trg_sync[2]) & q.trg_sync[2] & ~q.trg_lvl;
        trig_start = trig_edge & (q.slave_mode_select == SMODE_TRIGGER);
        xtrg_f = q.xtrg_lvl ^ q.external_trigger_polarity;
        cnt_wr = wr & (q.a_off == OFF_CNT);
        ctrl_wr = wr & (q.a_off == OFF_CTRL);
        sw_upd = wr & (q.a_off == OFF_EVGEN) & wd[BIT_SWUPD];
        tick = q.counter_enable_bit & ~cnt_wr & ~sw_upd;
        cnt_uev = 1'b0;
        fast_lvl = q.dir ^ (mode == OM_PWM2);
        flag_ok = ~center | (q.alignment_select[0] & q.dir) | (q.alignment_select[1] & ~q.dir);

        // ****************************************
        // bus address phase and pin synchronisers
        // ****************************************
        n.a_sel = acc;
        n.a_wr = ahb_req.hwrite;
        n.a_off = ahb_req.haddr[7:0];
        n.trg_sync = {q.trg_sync[1:0], trigger_input};
        n.xtrg_sync = {q.xtrg_sync[1:0], external_trigger_input};
        if (q.trg_sync[1] == q.trg_sync[2]) begin
            n.trg_lvl = q.trg_sync[2];
        end
        if (q.xtrg_sync[1] == q.xtrg_sync[2]) begin
            n.xtrg_lvl = q.xtrg_sync[2];
        end

        // ****************************************
        // software writes (data phase)
        // ****************************************
        if (wr) begin
            case (q.a_off)
                OFF_CTRL: begin
                    n.counter_enable_bit = wd[BIT_RUN];
                    if (!center) begin
                        n.dir = wd[BIT_DIR];
                    end
                    n.single_pulse_enable = wd[BIT_SPE];
                    n.alignment_select = wd[ALIGN_LO+:2];
                    n.reload_preload_enable = wd[BIT_RLDPRE];
                end
                OFF_SLAVE: begin
                    n.slave_mode_select = wd[SMODE_LO+:3];
                    n.external_trigger_polarity = wd[BIT_ETPOL];
                end
                OFF_CHMODE: begin
                    n.output_mode_field = wd[OMODE_LO+:3];
                    n.compare_preload_enable = wd[BIT_CPRE];
                    n.fast_output_enable = wd[BIT_FAST];
                    n.reference_clear_enable = wd[BIT_CLREN];
                    n.channel_polarity = wd[BIT_POL];
                end
                OFF_STATUS: begin
                    n.cmp_flag = q.cmp_flag & ~wd[BIT_CCF];
                    n.upd_flag = q.upd_flag & ~wd[BIT_UPDF];
                    n.trg_flag = q.trg_flag & ~wd[BIT_TRGF];
                end
                OFF_CNT: begin
                    n.counter_value = wd[CNT_W-1:0];
                    if (center && wd[CNT_W-1:0] == '0) begin
                        n.dir = 1'b0;
                    end else if (center && wd[CNT_W-1:0] == q.arr_act) begin
                        n.dir = 1'b1;
                    end
                end
                OFF_CMP: n.compare_value = wd[CNT_W-1:0];
                OFF_ARR: n.auto_reload_value = wd[CNT_W-1:0];
                default: ;
            endcase
        end

        // ****************************************
        // counter
        // ****************************************
        if (tick) begin
            if (!center && !q.dir) begin
                if (q.counter_value >= q.arr_act) begin
                    n.counter_value = '0;
                    cnt_uev = 1'b1;
                end else begin
                    n.counter_value = q.counter_value + 16'h1;
                end
            end else if (!center) begin
                if (q.counter_value == '0) begin
                    n.counter_value = q.arr_act;
                    cnt_uev = 1'b1;
                end else begin
                    n.counter_value = q.counter_value - 16'h1;
                end
            end else if (!q.dir) begin
                if (q.counter_value == q.arr_act - 16'h1) begin
                    n.counter_value = q.arr_act;
                    n.dir = 1'b1;
                    cnt_uev = 1'b1;
                end else begin
                    n.counter_value = q.counter_value + 16'h1;
                end
            end else begin
                if (q.counter_value == 16'h1) begin
                    n.counter_value = '0;
                    n.dir = 1'b0;
                    cnt_uev = 1'b1;
                end else begin
                    n.counter_value = q.counter_value - 16'h1;
                end
            end
            if (match && flag_ok) begin
                n.cmp_flag = 1'b1;
            end
        end
        update_event = cnt_uev | sw_upd;

        // ****************************************
        // reference generation
        // ****************************************
        n.prev_res = res;
        n.prev_mode = mode;
        case (mode)
            OM_ACTIVE: if (tick && match) n.ref_lvl = 1'b1;
            OM_INACTIVE: if (tick && match) n.ref_lvl = 1'b0;
            OM_TOGGLE: if (tick && match) n.ref_lvl = ~q.ref_lvl;
            OM_FORCE_LO: n.ref_lvl = 1'b0;
            OM_FORCE_HI: n.ref_lvl = 1'b1;
            OM_PWM1, OM_PWM2: begin
                if (q.fast_hold) begin
                    if (res == q.dir) begin
                        n.fast_hold = 1'b0;
                    end
                end else if (res != q.prev_res || q.prev_mode == OM_FROZEN) begin
                    n.ref_lvl = res ^ (mode == OM_PWM2);
                end
                if (trig_start && q.fast_output_enable) begin
                    n.ref_lvl = fast_lvl;
                    n.fast_hold = 1'b1;
                end
            end
            default: ;
        endcase
        if (!pwm) begin
            n.fast_hold = 1'b0;
        end

        // ****************************************
        // update event, single pulse, trigger
        // ****************************************
        if (update_event) begin
            n.upd_flag = 1'b1;
            n.clr_hold = 1'b0;
            n.fast_hold = 1'b0;
        end
        if (update_event || !n.compare_preload_enable) begin
            n.cmp_act = n.compare_value;
        end
        if (update_event || !n.reload_preload_enable) begin
            n.arr_act = n.auto_reload_value;
        end
        if (sw_upd) begin
            n.counter_value = (!center && q.dir) ? n.arr_act : '0;
        end
        if (cnt_uev && q.single_pulse_enable) begin
            n.counter_enable_bit = 1'b0;
        end
        if (trig_start) begin
            n.counter_enable_bit = 1'b1;
            n.trg_flag = 1'b1;
        end
        if (q.reference_clear_enable && xtrg_f) begin
            n.clr_hold = 1'b1;
        end
        n.ref_out = n.ref_lvl & ~(n.clr_hold & (n.output_mode_field[2:1] != 2'h2));
        n.pin_out = n.ref_out ^ n.channel_polarity;

        // ****************************************
        // read data, shows writes of this cycle
        // ****************************************
        n.rdata = '0;
        if (acc && !ahb_req.hwrite) begin
            case (ahb_req.haddr[7:0])
                OFF_CTRL: begin
                    n.rdata[BIT_RUN] = n.counter_enable_bit;
                    n.rdata[BIT_DIR] = n.dir;
                    n.rdata[BIT_SPE] = n.single_pulse_enable;
                    n.rdata[ALIGN_LO+:2] = n.alignment_select;
                    n.rdata[BIT_RLDPRE] = n.reload_preload_enable;
                end
                OFF_SLAVE: begin
                    n.rdata[SMODE_LO+:3] = n.slave_mode_select;
                    n.rdata[BIT_ETPOL] = n.external_trigger_polarity;
                end
                OFF_CHMODE: begin
                    n.rdata[OMODE_LO+:3] = n.output_mode_field;
                    n.rdata[BIT_CPRE] = n.compare_preload_enable;
                    n.rdata[BIT_FAST] = n.fast_output_enable;
                    n.rdata[BIT_CLREN] = n.reference_clear_enable;
                    n.rdata[BIT_POL] = n.channel_polarity;
                end
                OFF_STATUS: begin
                    n.rdata[BIT_CCF] = n.cmp_flag;
                    n.rdata[BIT_UPDF] = n.upd_flag;
                    n.rdata[BIT_TRGF] = n.trg_flag;
                end
                OFF_CNT: n.rdata[CNT_W-1:0] = n.counter_value;
                OFF_CMP: n.rdata[CNT_W-1:0] = n.compare_value;
                OFF_ARR: n.rdata[CNT_W-1:0] = n.auto_reload_value;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.auto_reload_value <= ARR_RST;
            q.arr_act <= ARR_RST;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    up_count_a: assert property (tick && !center && !q.dir && q.counter_value < q.arr_act
        |=> q.counter_value == $past(q.counter_value) + 16'h1) else $error("edge up count wrong");
    down_count_a: assert property (tick && !center && q.dir && q.counter_value != 0
        |=> q.counter_value == $past(q.counter_value) - 16'h1) else $error("edge down count wrong");
    pwm1_follow_a: assert property (mode == OM_PWM1 && q.prev_mode == OM_PWM1 && !q.fast_hold
        && !q.dir && res != q.prev_res && !trig_start |=> q.ref_lvl == $past(q.counter_value < q.cmp_act))
        else $error("pwm1 reference does not follow compare");
    zero_duty_a: assert property (!q.dir && q.cmp_act == 0 |-> !res) else $error("zero compare not low");
    full_duty_a: assert property (q.cmp_act > q.arr_act && q.counter_value <= q.arr_act |-> res)
        else $error("compare above reload not high");
    flag_down_a: assert property (q.alignment_select == ALIGN_DOWN && tick && match && !q.dir && !wr
        |=> q.cmp_flag == $past(q.cmp_flag)) else $error("flag set while counting up");
    dir_hold_a: assert property (center && ctrl_wr && !q.counter_enable_bit |=> $stable(q.dir))
        else $error("software changed direction in center mode");
    big_write_a: assert property (center && cnt_wr && wd[CNT_W-1:0] > q.arr_act |=> $stable(q.dir))
        else $error("direction changed on large write");
    zero_write_a: assert property (center && cnt_wr && wd[CNT_W-1:0] == 0
        |=> !q.dir && q.upd_flag == $past(q.upd_flag)) else $error("zero write wrong");
    one_shot_stop_a: assert property (cnt_uev && q.single_pulse_enable && !trig_start
        |=> !q.counter_enable_bit) else $error("single pulse did not stop");
    trig_run_a: assert property (trig_start |=> q.counter_enable_bit && q.trg_flag)
        else $error("trigger did not start counter");
    fast_ref_a: assert property (trig_start && q.fast_output_enable && pwm && !update_event
        |=> q.ref_lvl == $past(fast_lvl) && q.fast_hold) else $error("fast level not taken");
    fast_off_a: assert property (!pwm |=> !q.fast_hold) else $error("fast hold outside pwm");
    xtrg_clear_a: assert property (q.reference_clear_enable && xtrg_f ##1 q.output_mode_field[2:1] != 2'h2
        |-> !reference_output) else $error("reference not cleared");
    force_hi_a: assert property (mode == OM_FORCE_HI [*2] |-> reference_output)
        else $error("forced high lost");
    pin_pol_a: assert property (compare_pin_output == (reference_output ^ q.channel_polarity))
        else $error("pin polarity wrong");

    one_shot_c: cover property (trig_start ##[1:300] (cnt_uev && q.single_pulse_enable));
    center_turn_c: cover property (center && tick && !q.dir ##1 q.dir);
    xtrg_clear_c: cover property (q.clr_hold && pwm ##[1:300] !q.clr_hold);

endmodule : tpo_timer_pwm
